// ### design/acmp_pkg.sv
// Purpose: shared constants and carrier types for the comparator control block
// Assumes: AHB-Lite word access, register index times four gives the byte address
// Notes:   reset values and bit positions live here only
package acmp_pkg;

   // register indices; byte address is index * 4
   localparam logic [7:0]  IDX_CSR  = 8'h50;
   localparam logic [7:0]  IDX_CCB  = 8'h7B;
   localparam logic [7:0]  IDX_IST  = 8'h7C;
   localparam logic [7:0]  IDX_IMK  = 8'h7D;
   localparam logic [7:0]  IDX_PID  = 8'h7E;
   localparam logic [31:0] ADDR_CSR = {22'h000000, IDX_CSR, 2'h0};
   localparam logic [31:0] ADDR_CCB = {22'h000000, IDX_CCB, 2'h0};
   localparam logic [31:0] ADDR_IST = {22'h000000, IDX_IST, 2'h0};
   localparam logic [31:0] ADDR_IMK = {22'h000000, IDX_IMK, 2'h0};
   localparam logic [31:0] ADDR_PID = {22'h000000, IDX_PID, 2'h0};

   // comparator_control_status fields
   localparam int unsigned CSR_DIS  = 7;
   localparam int unsigned CSR_BG   = 6;
   localparam int unsigned CSR_RES  = 5;
   localparam int unsigned CSR_FLAG = 4;
   localparam int unsigned CSR_IE   = 3;
   localparam int unsigned CSR_CAP  = 2;
   localparam int unsigned CSR_MHI  = 1;
   localparam int unsigned CSR_MLO  = 0;
   // converter_control_b fields
   localparam int unsigned CCB_MUXEN = 6;
   localparam int unsigned CCB_TRHI  = 2;
   localparam int unsigned CCB_TRLO  = 0;
   // comparator_pin_input_disable fields
   localparam int unsigned PID_NEG = 1;
   localparam int unsigned PID_POS = 0;
   // interrupt status / mask field
   localparam int unsigned IST_CMP = 0;

   localparam logic [7:0] CSR_RST = 8'h00;
   localparam logic [7:0] CCB_RST = 8'h00;
   localparam logic [7:0] PID_RST = 8'h00;
   localparam logic       IMK_RST = 1'b1;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'b0;

   typedef enum logic [1:0] {
      ACMP_MODE_TOGGLE = 2'h0,
      ACMP_MODE_RSVD   = 2'h1,
      ACMP_MODE_FALL   = 2'h2,
      ACMP_MODE_RISE   = 2'h3
   } acmp_mode_t;

   typedef enum logic [2:0] {REG_NONE, REG_CSR, REG_CCB, REG_IST, REG_IMK, REG_PID} acmp_reg_t;
   typedef enum logic [0:0] {BUS_IDLE, BUS_WAIT} acmp_bus_t;

   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic        hready;
      logic [31:0] hwdata;
   } acmp_ahb_req_t;

   typedef struct packed {
      logic        hreadyout;
      logic        hresp;
      logic [31:0] hrdata;
   } acmp_ahb_rsp_t;

   // controls toward the analog comparator and its pins
   typedef struct packed {
      logic       power_down;
      logic       bandgap_select;
      logic       neg_use_mux;
      logic [2:0] neg_channel;
      logic       pos_pin_dig_off;
      logic       neg_pin_dig_off;
   } acmp_ana_t;

endpackage

// ### design/acmp_top.sv
// Purpose: digital control of the on-chip voltage comparator
// Assumes: raw comparator output is asynchronous; pins and enables synchronous
// Notes:   AHB-Lite slave with one wait state on every NONSEQ transfer; SEQ transfers are ignored
//
// Contract
// - result bit high when positive above negative
// - mux enabled, converter off: channel picks input
// - otherwise dedicated negative pin is used
// - bandgap select replaces the positive pin
// - raw output synchronised, one to two cycles
// - matching output event sets interrupt flag
// - request needs flag, enable and global enable
// - flag cleared by vector or writing one
// - mode: toggle, reserved, falling, rising
// - capture enable routes output to timer
// - disable bit powers the comparator off
// - input disable forces port bit to zero
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps

module acmp_top (
   input  wire logic                   clock_i,
   input  wire logic                   arst_n_i,
   input  wire acmp_pkg::acmp_ahb_req_t ahb_req_i,
   output      acmp_pkg::acmp_ahb_rsp_t ahb_rsp_o,
   input  wire logic                   comp_raw_i,
   input  wire logic                   converter_enable_i,
   input  wire logic [2:0]             channel_select_i,
   input  wire logic                   global_irq_en_i,
   input  wire logic                   irq_ack_i,
   input  wire logic [1:0]             pin_raw_i,
   output      acmp_pkg::acmp_ana_t     ana_o,
   output      logic [1:0]             port_in_o,
   output      logic [2:0]             trigger_source_o,
   output      logic                   capture_o,
   output      logic                   irq_o
);

   typedef struct packed {
      acmp_pkg::acmp_bus_t     bus_st;
      acmp_pkg::acmp_reg_t     sel;
      logic                    wr;
      acmp_pkg::acmp_ahb_rsp_t rsp;
      logic                    dis;
      logic                    bg;
      logic                    flag;
      logic                    ie;
      logic                    cap;
      logic [1:0]              mode;
      logic                    muxen;
      logic [2:0]              trig;
      logic [1:0]              pid;
      logic                    imk;
      logic                    sync1;
      logic                    sync2;
      logic                    prev;
      logic                    capture;
      logic                    irq;
      acmp_pkg::acmp_ana_t     ana;
      logic [1:0]              port_in;
   } acmp_state_t;

   localparam acmp_state_t ST_RST = '{
      bus_st:  acmp_pkg::BUS_IDLE,
      sel:     acmp_pkg::REG_NONE,
      wr:      1'b0,
      rsp:     '{hreadyout: 1'b1, hresp: acmp_pkg::HRESP_OKAY, hrdata: 32'h00000000},
      dis:     acmp_pkg::CSR_RST[acmp_pkg::CSR_DIS],
      bg:      acmp_pkg::CSR_RST[acmp_pkg::CSR_BG],
      flag:    acmp_pkg::CSR_RST[acmp_pkg::CSR_FLAG],
      ie:      acmp_pkg::CSR_RST[acmp_pkg::CSR_IE],
      cap:     acmp_pkg::CSR_RST[acmp_pkg::CSR_CAP],
      mode:    acmp_pkg::CSR_RST[acmp_pkg::CSR_MHI:acmp_pkg::CSR_MLO],
      muxen:   acmp_pkg::CCB_RST[acmp_pkg::CCB_MUXEN],
      trig:    acmp_pkg::CCB_RST[acmp_pkg::CCB_TRHI:acmp_pkg::CCB_TRLO],
      pid:     acmp_pkg::PID_RST[acmp_pkg::PID_NEG:acmp_pkg::PID_POS],
      imk:     acmp_pkg::IMK_RST,
      sync1:   1'b0,
      sync2:   1'b0,
      prev:    1'b0,
      capture: 1'b0,
      irq:     1'b0,
      ana:     '{power_down: 1'b0, bandgap_select: 1'b0, neg_use_mux: 1'b0,
                 neg_channel: 3'h0, pos_pin_dig_off: 1'b0, neg_pin_dig_off: 1'b0},
      port_in: 2'h0
   };

   acmp_state_t s_r;
   acmp_state_t s_nxt;

   // unmapped addresses decode to none: reads give zero, writes vanish
   function automatic acmp_pkg::acmp_reg_t reg_decode(input logic [31:0] addr);
      acmp_pkg::acmp_reg_t r;
      case (addr)
         acmp_pkg::ADDR_CSR: r = acmp_pkg::REG_CSR;
         acmp_pkg::ADDR_CCB: r = acmp_pkg::REG_CCB;
         acmp_pkg::ADDR_IST: r = acmp_pkg::REG_IST;
         acmp_pkg::ADDR_IMK: r = acmp_pkg::REG_IMK;
         acmp_pkg::ADDR_PID: r = acmp_pkg::REG_PID;
         default:            r = acmp_pkg::REG_NONE;
      endcase
      return r;
   endfunction

   function automatic logic [31:0] reg_read(input acmp_state_t s);
      logic [31:0] d;
      d = 32'h00000000;
      case (s.sel)
         acmp_pkg::REG_CSR: begin
            d[acmp_pkg::CSR_DIS]                    = s.dis;
            d[acmp_pkg::CSR_BG]                     = s.bg;
            d[acmp_pkg::CSR_RES]                    = s.sync2;
            d[acmp_pkg::CSR_FLAG]                   = s.flag;
            d[acmp_pkg::CSR_IE]                     = s.ie;
            d[acmp_pkg::CSR_CAP]                    = s.cap;
            d[acmp_pkg::CSR_MHI:acmp_pkg::CSR_MLO]  = s.mode;
         end
         acmp_pkg::REG_CCB: begin
            d[acmp_pkg::CCB_MUXEN]                  = s.muxen;
            d[acmp_pkg::CCB_TRHI:acmp_pkg::CCB_TRLO] = s.trig;
         end
         acmp_pkg::REG_IST: d[acmp_pkg::IST_CMP] = s.flag;
         acmp_pkg::REG_IMK: d[acmp_pkg::IST_CMP] = s.imk;
         acmp_pkg::REG_PID: d[acmp_pkg::PID_NEG:acmp_pkg::PID_POS] = s.pid;
         default:           d = 32'h00000000;
      endcase
      return d;
   endfunction

   always_comb begin
      logic        accept;
      logic        wr_now;
      logic [7:0]  wd;
      logic        flag_clr;
      logic        ev;
      logic        toggled;
      accept   = 1'b0;
      wr_now   = 1'b0;
      wd       = 8'h00;
      flag_clr = 1'b0;
      ev       = 1'b0;
      toggled  = 1'b0;
      s_nxt    = s_r;

      // bus slave: address taken, one wait cycle, then answer
      case (s_r.bus_st)
         acmp_pkg::BUS_IDLE: begin
            accept = ahb_req_i.hsel & ahb_req_i.hready &
                     (ahb_req_i.htrans == acmp_pkg::HTRANS_NONSEQ);
            if (accept) begin
               s_nxt.bus_st        = acmp_pkg::BUS_WAIT;
               s_nxt.sel           = reg_decode(ahb_req_i.haddr);
               s_nxt.wr            = ahb_req_i.hwrite;
               s_nxt.rsp.hreadyout = 1'b0;
            end
         end
         acmp_pkg::BUS_WAIT: begin
            // the wait cycle lets a read see every earlier write
            s_nxt.bus_st        = acmp_pkg::BUS_IDLE;
            s_nxt.rsp.hreadyout = 1'b1;
            wr_now              = s_r.wr;
            wd                  = ahb_req_i.hwdata[7:0];
            s_nxt.rsp.hrdata    = s_r.wr ? 32'h00000000 : reg_read(s_r);
         end
         default: begin
            s_nxt.bus_st        = acmp_pkg::BUS_IDLE;
            s_nxt.rsp.hreadyout = 1'b1;
         end
      endcase
      s_nxt.rsp.hresp = acmp_pkg::HRESP_OKAY;

      if (wr_now) begin
         case (s_r.sel)
            acmp_pkg::REG_CSR: begin
               s_nxt.dis  = wd[acmp_pkg::CSR_DIS];
               s_nxt.bg   = wd[acmp_pkg::CSR_BG];
               s_nxt.ie   = wd[acmp_pkg::CSR_IE];
               s_nxt.cap  = wd[acmp_pkg::CSR_CAP];
               s_nxt.mode = wd[acmp_pkg::CSR_MHI:acmp_pkg::CSR_MLO];
               flag_clr   = wd[acmp_pkg::CSR_FLAG];
            end
            acmp_pkg::REG_CCB: begin
               s_nxt.muxen = wd[acmp_pkg::CCB_MUXEN];
               s_nxt.trig  = wd[acmp_pkg::CCB_TRHI:acmp_pkg::CCB_TRLO];
            end
            acmp_pkg::REG_IST: flag_clr  = wd[acmp_pkg::IST_CMP];
            acmp_pkg::REG_IMK: s_nxt.imk = wd[acmp_pkg::IST_CMP];
            acmp_pkg::REG_PID: s_nxt.pid = wd[acmp_pkg::PID_NEG:acmp_pkg::PID_POS];
            default: ;
         endcase
      end

      // two-stage synchroniser; only sync2 feeds any logic
      s_nxt.sync1 = comp_raw_i;
      s_nxt.sync2 = s_r.sync1;
      s_nxt.prev  = s_r.sync2;

      toggled = s_r.sync2 ^ s_r.prev;
      // no gating by the disable bit: changing it may fire an event
      case (acmp_pkg::acmp_mode_t'(s_r.mode))
         acmp_pkg::ACMP_MODE_TOGGLE: ev = toggled;
         acmp_pkg::ACMP_MODE_FALL:   ev = toggled & ~s_r.sync2;
         acmp_pkg::ACMP_MODE_RISE:   ev = toggled & s_r.sync2;
         default:                    ev = 1'b0;
      endcase

      // a new event beats a clear in the same cycle
      s_nxt.flag = (s_r.flag & ~(flag_clr | irq_ack_i)) | ev;

      s_nxt.irq     = s_nxt.flag & s_nxt.ie & global_irq_en_i & s_nxt.imk;
      s_nxt.capture = s_nxt.cap & s_r.sync2;

      s_nxt.ana.power_down     = s_nxt.dis;
      s_nxt.ana.bandgap_select = s_nxt.bg;
      // mux path also needs the converter disabled
      s_nxt.ana.neg_use_mux    = s_nxt.muxen & ~converter_enable_i;
      s_nxt.ana.neg_channel    = s_nxt.ana.neg_use_mux ? channel_select_i : 3'h0;
      s_nxt.ana.pos_pin_dig_off = s_nxt.pid[acmp_pkg::PID_POS];
      s_nxt.ana.neg_pin_dig_off = s_nxt.pid[acmp_pkg::PID_NEG];
      s_nxt.port_in = pin_raw_i & ~s_nxt.pid;
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_r <= ST_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign ahb_rsp_o        = s_r.rsp;
   assign ana_o            = s_r.ana;
   assign port_in_o        = s_r.port_in;
   assign trigger_source_o = s_r.trig;
   assign capture_o        = s_r.capture;
   assign irq_o            = s_r.irq;

endmodule // acmp_top

// ### test/acmp_ana_model.sv
// Purpose: analog side: pins, channels, bandgap, comparator
// Assumes: voltages as 8-bit codes, channel k sits at k*32+16
// Notes:   a powered-down comparator idles low
`timescale 1ns/1ps
module acmp_ana_model #(
   parameter logic [7:0] BG  = 8'h80,
   parameter logic [7:0] NEG = 8'h40
) (
   input  wire acmp_pkg::acmp_ana_t ana_i,
   input  wire logic [7:0]          pos_i,
   output      logic                raw_o
);
   logic [7:0] p_w;
   logic [7:0] n_w;
   assign p_w = ana_i.bandgap_select ? BG : pos_i;
   assign n_w = ana_i.neg_use_mux ? {ana_i.neg_channel, 5'h10} : NEG;
   assign raw_o = !ana_i.power_down && p_w > n_w;
endmodule // acmp_ana_model

// ### test/acmp_monitor.sv
// Purpose: port checks on the comparator control block
// Assumes: one clock, async active-low reset
// Notes:   bound to acmp_top below
`timescale 1ns/1ps
module acmp_monitor (
   input wire logic                    clock_i,
   input wire logic                    arst_n_i,
   input wire acmp_pkg::acmp_ahb_req_t ahb_req_i,
   input wire acmp_pkg::acmp_ahb_rsp_t ahb_rsp_o,
   input wire logic                    comp_raw_i,
   input wire logic                    converter_enable_i,
   input wire logic [2:0]              channel_select_i,
   input wire logic                    global_irq_en_i,
   input wire logic                    irq_ack_i,
   input wire logic [1:0]              pin_raw_i,
   input wire acmp_pkg::acmp_ana_t     ana_o,
   input wire logic [1:0]              port_in_o,
   input wire logic [2:0]              trigger_source_o,
   input wire logic                    capture_o,
   input wire logic                    irq_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);
   wire take_w = ahb_req_i.hsel && ahb_req_i.hready && ahb_rsp_o.hreadyout
                 && ahb_req_i.htrans == acmp_pkg::HTRANS_NONSEQ;
   AST_WAIT: assert property (take_w |=> !ahb_rsp_o.hreadyout ##1 ahb_rsp_o.hreadyout)
      else $error("wait state");
   AST_MUX_OFF: assert property (converter_enable_i
      |=> !ana_o.neg_use_mux && ana_o.neg_channel == 3'h0) else $error("mux on");
   AST_MUX_CH: assert property (ana_o.neg_use_mux
      |-> ana_o.neg_channel == $past(channel_select_i)) else $error("channel");
   AST_PIN_OFF: assert property (ana_o.neg_pin_dig_off && $past(ana_o.neg_pin_dig_off)
      |-> !port_in_o[1]) else $error("pin off");
   AST_PIN_ON: assert property ($past(arst_n_i) && !$past(ana_o.pos_pin_dig_off)
      && !ana_o.pos_pin_dig_off |-> port_in_o[0] == $past(pin_raw_i[0])) else $error("pin");
   AST_GIE: assert property (irq_o |-> $past(global_irq_en_i))
      else $error("irq");
   AST_CAP: assert property (capture_o |-> $past(comp_raw_i, 3))
      else $error("capture");
   AST_ACK: assert property (irq_ack_i && $stable(comp_raw_i) &&
      $past(comp_raw_i, 2) == comp_raw_i && $past(comp_raw_i, 3) == comp_raw_i |=> !irq_o)
      else $error("ack");
   cover property (take_w && !ahb_req_i.hwrite);
   cover property (irq_o && irq_ack_i);
   cover property (capture_o);
endmodule // acmp_monitor
bind acmp_top acmp_monitor mon (.*);

// ### test/tb.sv
// Purpose: self-checking bench for the comparator control block
// Assumes: analog side modelled, converter power reduction kept clear
// Notes:   bus reads are checked from a queue by a watcher
`timescale 1ns/1ps
module tb;
   acmp_pkg::acmp_ahb_req_t ahb_req_i = '0;
   acmp_pkg::acmp_ahb_rsp_t ahb_rsp_o;
   acmp_pkg::acmp_ana_t     ana_o;
   logic       clock_i = 1'b0;
   logic       arst_n_i = 1'b0;
   logic       comp_raw_i;
   logic       converter_enable_i = 1'b0;
   logic       global_irq_en_i = 1'b0;
   logic       irq_ack_i = 1'b0;
   logic       rd_pend = 1'b0;
   logic       capture_o;
   logic       irq_o;
   logic [2:0] channel_select_i = 3'h0;
   logic [2:0] trigger_source_o;
   logic [1:0] pin_raw_i = 2'h0;
   logic [1:0] port_in_o;
   logic [7:0] pos = 8'h00;
   logic [15:0] note;
   logic [15:0] exp_q[$];
   int         failures = 0;
   int         checked = 0;
   int         cycles = 0;
   int         i;
   acmp_top uut (.*);
   acmp_ana_model model (.ana_i(ana_o), .pos_i(pos), .raw_o(comp_raw_i));
   initial forever #12.5 clock_i = ~clock_i;
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      checked++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   // hready held high: the slave ignores idle cycles while it stalls
   task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d,
                       input logic [15:0] me);
      @(posedge clock_i);
      ahb_req_i <= '{1'b1, a, acmp_pkg::HTRANS_NONSEQ, w, 3'h2, 1'b1, 32'h0};
      do @(posedge clock_i); while (ahb_rsp_o.hreadyout !== 1'b1);
      ahb_req_i <= '{1'b0, a, 2'h0, w, 3'h2, 1'b1, {24'h0, d}};
      if (!w) exp_q.push_back(me);
      rd_pend <= !w;
      do @(posedge clock_i); while (ahb_rsp_o.hreadyout !== 1'b1);
      rd_pend <= 1'b0;
   endtask
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      xfer(1'b1, a, d, 16'h0);
   endtask
   task automatic rd(input logic [31:0] a, input logic [7:0] m, input logic [7:0] e);
      xfer(1'b0, a, 8'h0, {m, e});
   endtask
   task automatic final_report();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clock_i) begin
      if (rd_pend && ahb_rsp_o.hreadyout === 1'b1) begin
         note = exp_q.pop_front();
         chk("hrdata", note[7:0], ahb_rsp_o.hrdata[7:0] & note[15:8]);
      end
   end
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 6000) begin
         failures++;
         final_report();
      end
   end
   initial begin
      void'($urandom(32'h556d));
      repeat (4) @(posedge clock_i);
      arst_n_i <= 1'b1;
      rd(acmp_pkg::ADDR_CSR, 8'hFF, 8'h00);
      rd(acmp_pkg::ADDR_CCB, 8'hFF, 8'h00);
      rd(acmp_pkg::ADDR_IMK, 8'h01, 8'h01);
      rd(acmp_pkg::ADDR_PID, 8'h03, 8'h00);
      wr(32'h0000_0104, 8'hFF);
      rd(32'h0000_0104, 8'hFF, 8'h00);
      wr(acmp_pkg::ADDR_CCB, 8'h45);
      rd(acmp_pkg::ADDR_CCB, 8'hFF, 8'h45);
      chk("trigger", 8'h05, 8'(trigger_source_o));
      for (i = 0; i < 8; i++) begin
         channel_select_i <= 3'(i);
         pos <= 8'($urandom);
         wt(4);
         chk("mux", 8'(i * 2 + 1), {4'h0, ana_o.neg_channel, ana_o.neg_use_mux});
         rd(acmp_pkg::ADDR_CSR, 8'h20, 8'(pos > {3'(i), 5'h10}) << 5);
      end
      converter_enable_i <= 1'b1;
      wt(4);
      rd(acmp_pkg::ADDR_CSR, 8'h20, 8'(pos > 8'h40) << 5);
      global_irq_en_i <= 1'b1;
      for (i = 3; i >= 0; i--) begin
         wr(acmp_pkg::ADDR_CSR, 8'(i));
         wr(acmp_pkg::ADDR_IST, 8'h01);
         pos <= 8'h00;
         wt(5);
         wr(acmp_pkg::ADDR_CSR, 8'(8 + i));
         pos <= 8'hFF;
         wt(5);
         chk("rise", 8'(i == 0 || i == 3), 8'(irq_o));
         wr(acmp_pkg::ADDR_CSR, 8'(8 + i));
         rd(acmp_pkg::ADDR_CSR, 8'h10, 8'(i == 0 || i == 3) << 4);
         irq_ack_i <= 1'b1;
         wt(1);
         irq_ack_i <= 1'b0;
         wt(2);
         chk("ack", 8'h00, 8'(irq_o));
         pos <= 8'h00;
         wt(5);
         chk("fall", 8'(i == 0 || i == 2), 8'(irq_o));
         wr(acmp_pkg::ADDR_CSR, 8'(16 + i));
      end
      wr(acmp_pkg::ADDR_IMK, 8'h00);
      wr(acmp_pkg::ADDR_CSR, 8'h08);
      pos <= 8'hFF;
      wt(5);
      chk("masked", 8'h00, 8'(irq_o));
      rd(acmp_pkg::ADDR_IST, 8'h01, 8'h01);
      wr(acmp_pkg::ADDR_IMK, 8'h01);
      wt(2);
      chk("unmasked", 8'h01, 8'(irq_o));
      global_irq_en_i <= 1'b0;
      wt(2);
      chk("global", 8'h00, 8'(irq_o));
      wr(acmp_pkg::ADDR_CSR, 8'h14);
      wt(4);
      chk("cap on", 8'h01, 8'(capture_o));
      wr(acmp_pkg::ADDR_CSR, 8'h10);
      wt(2);
      chk("cap off", 8'h00, 8'(capture_o));
      pos <= 8'h00;
      wr(acmp_pkg::ADDR_CSR, 8'h50);
      wt(4);
      rd(acmp_pkg::ADDR_CSR, 8'h60, 8'h60);
      wr(acmp_pkg::ADDR_CSR, 8'h90);
      wt(4);
      chk("power", 8'h01, 8'(ana_o.power_down));
      rd(acmp_pkg::ADDR_CSR, 8'hA0, 8'h80);
      for (i = 0; i < 4; i++) begin
         pin_raw_i <= 2'($urandom);
         wr(acmp_pkg::ADDR_PID, 8'(i));
         wt(2);
         chk("port", 8'(pin_raw_i & ~2'(i)), 8'(port_in_o));
         rd(acmp_pkg::ADDR_PID, 8'h03, 8'(i));
      end
      final_report();
   end
endmodule // tb
